// [rtl/fan_acoustic_pkg.sv]
// Constants, field layout and ramp table of the acoustic smoothing block
package fan_acoustic_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] ACOUSTIC_ONE_ADDR  = 8'h62; // Ramp control one
	localparam logic [7:0] RAMP_CONFIG_ADDR   = 8'h70; // Lock and slowdown
	localparam logic [7:0] RAMP_STATUS_ADDR   = 8'h71; // Ramped duty readback
	localparam logic [7:0] ACOUSTIC_ONE_RESET = 8'h00;
	localparam logic [7:0] RAMP_CONFIG_RESET  = 8'h00;
	localparam logic [7:0] READ_ZERO          = 8'h00;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int RATE_LSB         = 0; // Ramp rate code, three bits
	localparam int RATE_MSB         = 2;
	localparam int SMOOTH_BIT       = 3; // Remote one smoothing enable
	localparam int TACH_ALIGN_BIT   = 4; // Tachometer grouping
	localparam int FLOOR_ONE_BIT    = 5; // Floor select, output one
	localparam int FLOOR_TWO_BIT    = 6; // Floor select, output two
	localparam int FLOOR_THREE_BIT  = 7; // Floor select, output three
	localparam int CFG_LOCK_BIT     = 0; // Set-only write lock
	localparam int CFG_SLOW_BIT     = 1; // Slow ramp option
	localparam int CFG_QUARTER_BIT  = 2; // Further slowdown by four

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam longint CLK_MHZ           = 250;
	localparam longint RAMP_FULL_FAST_MS = 37500; // 0 to 100 percent
	localparam longint RAMP_FULL_SLOW_MS = 52200; // Same, slow option
	localparam longint DUTY_FULL_STEPS   = 255;   // Single-step sweep
	localparam logic [1:0] QUARTER_LAST  = 2'h3;  // Four slots per step
	// One slot is the sweep time divided by the steps of a unit ramp
	localparam longint SLOT_FAST_CYCLES =
		(RAMP_FULL_FAST_MS * 1000 * CLK_MHZ) / DUTY_FULL_STEPS;
	localparam longint SLOT_SLOW_CYCLES =
		(RAMP_FULL_SLOW_MS * 1000 * CLK_MHZ) / DUTY_FULL_STEPS;

	// Duty increment per ramp step for each ramp rate code
	function automatic logic [7:0] ramp_increment(input logic [2:0] code);
		case (code)
			3'h0:    ramp_increment = 8'h01;
			3'h1:    ramp_increment = 8'h02;
			3'h2:    ramp_increment = 8'h03;
			3'h3:    ramp_increment = 8'h04;
			3'h4:    ramp_increment = 8'h08;
			3'h5:    ramp_increment = 8'h0C;
			3'h6:    ramp_increment = 8'h18;
			default: ramp_increment = 8'h30;
		endcase
	endfunction : ramp_increment

endpackage : fan_acoustic_pkg

// [rtl/ramp_slot_timer.sv]
// Time slot generator with slow option and divide-by-four prescale
`timescale 1ns/1ns
module ramp_slot_timer #(
	parameter int unsigned FAST_CYCLES = 32'd36764705,
	parameter int unsigned SLOW_CYCLES = 32'd51176470
) (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic slow_i,       // Slow ramp option
	input  wire logic quarter_i,    // Further slowdown by four
	output logic      slot_tick_o,  // One pulse per time slot
	output logic      ramp_tick_o   // One pulse per ramp step
);

	initial begin
		if (FAST_CYCLES < 2 || SLOW_CYCLES < 2)
			$error("slot periods must be at least two cycles");
	end

	logic [31:0] count;     // Cycles within the slot
	logic        slow_q;    // Slow option seen last cycle
	logic [1:0]  prescale;  // Slots within a quartered step
	logic [31:0] period;    // Active slot length
	logic        wrap;      // Last cycle of a slot
	logic        changed;   // Slow option just toggled

	assign period  = slow_i ? SLOW_CYCLES : FAST_CYCLES;
	assign changed = slow_i != slow_q;
	assign wrap    = count == period - 32'h1;

	// -----------------------------------------------------------------
	// Slot counter; a mode change restarts the slot cleanly
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count       <= 32'h0;
			slow_q      <= 1'b0;
			slot_tick_o <= 1'b0;
		end else begin
			slow_q <= slow_i;
			if (changed || wrap) begin
				count <= 32'h0;
			end else begin
				count <= count + 32'h1;
			end
			slot_tick_o <= wrap && !changed;
		end
	end

	// -----------------------------------------------------------------
	// Quarter prescale: only every fourth slot moves the duty
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescale    <= 2'h0;
			ramp_tick_o <= 1'b0;
		end else begin
			if (wrap && !changed) begin
				prescale <= prescale + 2'h1;
			end
			ramp_tick_o <= wrap && !changed &&
				(!quarter_i || prescale == fan_acoustic_pkg::QUARTER_LAST);
		end
	end

endmodule : ramp_slot_timer

// [rtl/duty_ramp_limiter.sv]
// Rate limiter that walks the duty toward its target one ramp step at a time
`timescale 1ns/1ns
module duty_ramp_limiter (
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       tick_i,    // One ramp step may be taken
	input  wire logic       smooth_i,  // Smoothing enabled
	input  wire logic [2:0] code_i,    // Ramp rate code
	input  wire logic [7:0] target_i,  // Newly computed duty
	output logic      [7:0] duty_o     // Ramped duty
);

	logic [7:0] step;       // Increment for the current code
	logic [7:0] distance;   // Gap between duty and target
	logic [7:0] next_duty;  // Duty after this cycle

	// -----------------------------------------------------------------
	// Next duty: clamp the step so the target is never overshot
	// -----------------------------------------------------------------
	always_comb begin
		step      = fan_acoustic_pkg::ramp_increment(code_i);
		distance  = (target_i > duty_o) ? target_i - duty_o
		                                : duty_o - target_i;
		next_duty = duty_o;
		if (!smooth_i) begin
			next_duty = target_i;
		end else if (tick_i) begin
			if (distance <= step) begin
				next_duty = target_i;
			end else if (target_i > duty_o) begin
				next_duty = duty_o + step;
			end else begin
				next_duty = duty_o - step;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_o <= 8'h00;
		end else begin
			duty_o <= next_duty;
		end
	end

endmodule : duty_ramp_limiter

// [rtl/fan_drive_acoustic_smoothing.sv]
// Acoustic smoothing, tachometer grouping and floor control of fan drives
//
// Function
// - Remote one duty ramps gradually to target
// - Codes give steps 1..48; 37.5 s sweep
// - Slow option stretches sweep to 52.2 s
// - Smoothing enable bit gates remote one ramping
// - Alignment bit picks tachometer grouping on drive three
// - Output one floor: off or minimum duty
// - Output two floor: off or minimum duty
// - Output three floor: off or minimum duty
// - Lock makes control register read-only
// - Slowdown bit divides ramp rate by four
`timescale 1ns/1ns
module fan_drive_acoustic_smoothing #(
	parameter int unsigned SLOT_FAST_CYCLES =
		32'(fan_acoustic_pkg::SLOT_FAST_CYCLES),
	parameter int unsigned SLOT_SLOW_CYCLES =
		32'(fan_acoustic_pkg::SLOT_SLOW_CYCLES)
) (
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] reg_addr_i,            // Register address
	input  wire logic [7:0] reg_wdata_i,           // Write data
	input  wire logic       reg_wr_i,              // Write strobe
	input  wire logic       reg_rd_i,              // Read strobe
	output logic      [7:0] reg_rdata_o,           // Read data, next cycle
	input  wire logic [7:0] remote_one_target_i,   // Remote one duty
	input  wire logic [7:0] bypass_duty_i,         // Duty from other sources
	input  wire logic [2:0] remote_one_controls_i, // Output follows remote one
	input  wire logic [2:0] auto_mode_i,           // Output in automatic mode
	input  wire logic [2:0] below_floor_i,         // Below minimum - hysteresis
	input  wire logic [7:0] min_duty_one_i,        // Programmed minimum duty
	input  wire logic [7:0] min_duty_two_i,
	input  wire logic [7:0] min_duty_three_i,
	output logic      [7:0] fan_drive_one_o,       // Duty to output one
	output logic      [7:0] fan_drive_two_o,
	output logic      [7:0] fan_drive_three_o,
	output logic            speed_sense_two_aligned_o,
	output logic            speed_sense_three_aligned_o,
	output logic            speed_sense_four_aligned_o
);

	initial begin
		if (SLOT_FAST_CYCLES < 2 || SLOT_SLOW_CYCLES < 2)
			$error("slot periods must be at least two cycles");
	end

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	logic [7:0] acoustic_ramp_control_one; // Control register
	logic [7:0] ramp_config;               // Lock and slowdown bits
	logic       locked;                    // Writes to control refused
	logic       slot_tick;                 // One pulse per slot
	logic       ramp_tick;                 // One pulse per ramp step
	logic [7:0] ramped_duty;               // Limited remote one duty
	logic [2:0] ramp_rate_code;            // Field views
	logic       remote_one_smoothing_on;
	logic       drive_one_floor_select;
	logic       drive_two_floor_select;
	logic       drive_three_floor_select;
	logic       slow_ramp;
	logic       quarter_ramp;

	assign ramp_rate_code = acoustic_ramp_control_one[
		fan_acoustic_pkg::RATE_MSB:fan_acoustic_pkg::RATE_LSB];
	assign remote_one_smoothing_on =
		acoustic_ramp_control_one[fan_acoustic_pkg::SMOOTH_BIT];
	assign drive_one_floor_select =
		acoustic_ramp_control_one[fan_acoustic_pkg::FLOOR_ONE_BIT];
	assign drive_two_floor_select =
		acoustic_ramp_control_one[fan_acoustic_pkg::FLOOR_TWO_BIT];
	assign drive_three_floor_select =
		acoustic_ramp_control_one[fan_acoustic_pkg::FLOOR_THREE_BIT];
	assign locked       = ramp_config[fan_acoustic_pkg::CFG_LOCK_BIT];
	assign slow_ramp    = ramp_config[fan_acoustic_pkg::CFG_SLOW_BIT];
	assign quarter_ramp = ramp_config[fan_acoustic_pkg::CFG_QUARTER_BIT];

	// Duty to one output after the floor decision below the threshold
	function automatic logic [7:0] floor_duty(
		input logic       auto_mode,
		input logic       below,
		input logic       floor_sel,
		input logic [7:0] min_duty,
		input logic [7:0] duty
	);
		if (auto_mode && below) begin
			floor_duty = floor_sel ? min_duty : 8'h00;
		end else begin
			floor_duty = duty;
		end
	endfunction : floor_duty

	// -----------------------------------------------------------------
	// Register writes
	// -----------------------------------------------------------------
	// Control register: once locked it only changes through reset
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acoustic_ramp_control_one <= fan_acoustic_pkg::ACOUSTIC_ONE_RESET;
		end else if (reg_wr_i && !locked &&
			reg_addr_i == fan_acoustic_pkg::ACOUSTIC_ONE_ADDR) begin
			acoustic_ramp_control_one <= reg_wdata_i;
		end
	end

	// Config register: lock is set-only so software cannot undo it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ramp_config <= fan_acoustic_pkg::RAMP_CONFIG_RESET;
		end else if (reg_wr_i && !locked &&
			reg_addr_i == fan_acoustic_pkg::RAMP_CONFIG_ADDR) begin
			ramp_config <= {5'h00, reg_wdata_i[2:0]};
		end
	end

	// -----------------------------------------------------------------
	// Register reads, data one cycle after the strobe
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= fan_acoustic_pkg::READ_ZERO;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				fan_acoustic_pkg::ACOUSTIC_ONE_ADDR:
					reg_rdata_o <= acoustic_ramp_control_one;
				fan_acoustic_pkg::RAMP_CONFIG_ADDR:
					reg_rdata_o <= ramp_config;
				fan_acoustic_pkg::RAMP_STATUS_ADDR:
					reg_rdata_o <= ramped_duty;
				// Unmapped addresses read as zero
				default:
					reg_rdata_o <= fan_acoustic_pkg::READ_ZERO;
			endcase
		end else begin
			reg_rdata_o <= fan_acoustic_pkg::READ_ZERO;
		end
	end

	// -----------------------------------------------------------------
	// Slot timing and ramp limiter
	// -----------------------------------------------------------------
	// Slow option stretches the slot, slowdown passes one slot in four
	ramp_slot_timer #(
		.FAST_CYCLES (SLOT_FAST_CYCLES),
		.SLOW_CYCLES (SLOT_SLOW_CYCLES)
	) slot_timer (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_i),
		.slow_i      (slow_ramp),
		.quarter_i   (quarter_ramp),
		.slot_tick_o (slot_tick),
		.ramp_tick_o (ramp_tick)
	);

	// Remote one duty walks toward its target at the coded rate
	duty_ramp_limiter ramp_limiter (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.tick_i     (ramp_tick),
		.smooth_i   (remote_one_smoothing_on),
		.code_i     (ramp_rate_code),
		.target_i   (remote_one_target_i),
		.duty_o     (ramped_duty)
	);

	// -----------------------------------------------------------------
	// Fan drive outputs with floor behaviour
	// -----------------------------------------------------------------
	// Floor bit one holds the minimum, zero drops the output to 0%
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fan_drive_one_o   <= 8'h00;
			fan_drive_two_o   <= 8'h00;
			fan_drive_three_o <= 8'h00;
		end else begin
			fan_drive_one_o <= floor_duty(auto_mode_i[0], below_floor_i[0],
				drive_one_floor_select, min_duty_one_i,
				remote_one_controls_i[0] ? ramped_duty : bypass_duty_i);
			fan_drive_two_o <= floor_duty(auto_mode_i[1], below_floor_i[1],
				drive_two_floor_select, min_duty_two_i,
				remote_one_controls_i[1] ? ramped_duty : bypass_duty_i);
			fan_drive_three_o <= floor_duty(auto_mode_i[2],
				below_floor_i[2], drive_three_floor_select,
				min_duty_three_i,
				remote_one_controls_i[2] ? ramped_duty : bypass_duty_i);
		end
	end

	// -----------------------------------------------------------------
	// Tachometer grouping on drive three
	// -----------------------------------------------------------------
	// Three and four always follow drive three; two joins when set
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			speed_sense_two_aligned_o   <= 1'b0;
			speed_sense_three_aligned_o <= 1'b0;
			speed_sense_four_aligned_o  <= 1'b0;
		end else begin
			speed_sense_two_aligned_o <=
				acoustic_ramp_control_one[fan_acoustic_pkg::TACH_ALIGN_BIT];
			speed_sense_three_aligned_o <= 1'b1;
			speed_sense_four_aligned_o  <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Assertions and their helper logic
	// -----------------------------------------------------------------
	// Slot spacing is only checked once a tick has followed a mode change
	logic [31:0] slot_gap;
	logic        slot_armed;
	logic        slow_prev;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slot_gap   <= 32'h0;
			slot_armed <= 1'b0;
			slow_prev  <= 1'b0;
		end else begin
			slow_prev <= slow_ramp;
			slot_gap  <= (slot_tick || slow_ramp != slow_prev) ? 32'h0
			                                                  : slot_gap + 32'h1;
			if (slow_ramp != slow_prev) begin
				slot_armed <= 1'b0;
			end else if (slot_tick) begin
				slot_armed <= 1'b1;
			end
		end
	end

	ramp_step_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(remote_one_smoothing_on && ramp_tick &&
		 remote_one_target_i > ramped_duty &&
		 remote_one_target_i - ramped_duty >
		 fan_acoustic_pkg::ramp_increment(ramp_rate_code))
		|=> ramped_duty == $past(ramped_duty) +
		    fan_acoustic_pkg::ramp_increment($past(ramp_rate_code)))
		else $error("ramped duty did not rise by the coded step");

	ramp_hold_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(remote_one_smoothing_on && !ramp_tick)
		|=> $stable(ramped_duty))
		else $error("ramped duty moved outside a ramp step");

	smooth_off_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!remote_one_smoothing_on
		|=> ramped_duty == $past(remote_one_target_i))
		else $error("duty did not follow target with smoothing off");

	slow_slot_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot_tick && slot_armed && slow_ramp && slow_ramp == slow_prev)
		|-> slot_gap == SLOT_SLOW_CYCLES - 32'h1)
		else $error("slow slot length is wrong");

	quarter_tick_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(quarter_ramp && ramp_tick) |-> slot_tick)
		else $error("ramp step without a slot under slowdown");

	tach_group_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		rst_n_i |=> speed_sense_two_aligned_o ==
		$past(acoustic_ramp_control_one[fan_acoustic_pkg::TACH_ALIGN_BIT])
		&& speed_sense_three_aligned_o && speed_sense_four_aligned_o)
		else $error("tachometer grouping does not match control bit");

	floor_one_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(auto_mode_i[0] && below_floor_i[0])
		|=> fan_drive_one_o == ($past(drive_one_floor_select) ?
		    $past(min_duty_one_i) : 8'h00))
		else $error("output one floor duty is wrong");

	floor_two_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(auto_mode_i[1] && below_floor_i[1] && drive_two_floor_select)
		|=> fan_drive_two_o == $past(min_duty_two_i))
		else $error("output two did not hold its minimum");

	floor_three_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(auto_mode_i[2] && below_floor_i[2] && !drive_three_floor_select)
		|=> fan_drive_three_o == 8'h00)
		else $error("output three did not turn off");

	floor_min_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(auto_mode_i[0] && below_floor_i[0] && drive_one_floor_select)
		|=> fan_drive_one_o == $past(min_duty_one_i))
		else $error("floor bit one did not hold minimum");

	lock_hold_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		locked |=> $stable(acoustic_ramp_control_one) && locked)
		else $error("control register changed while locked");

	// Slot phase is free when slowdown starts, so skip the first two steps
	logic [2:0] slots_since_step;
	logic [1:0] quarter_seen;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slots_since_step <= 3'h0;
			quarter_seen     <= 2'h0;
		end else begin
			slots_since_step <= ramp_tick ? 3'h0
				: slots_since_step + {2'h0, slot_tick};
			if (!quarter_ramp) begin
				quarter_seen <= 2'h0;
			end else if (ramp_tick && quarter_seen != 2'h2) begin
				quarter_seen <= quarter_seen + 2'h1;
			end
		end
	end

	quarter_gap_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(quarter_ramp && quarter_seen == 2'h2 && ramp_tick)
		|-> slots_since_step == 3'h3)
		else $error("slowdown step not four slots apart");

endmodule : fan_drive_acoustic_smoothing

// [testbench/fan_bank_model.sv]
// Behavioural fans and tachometers hung on drive output three
`timescale 1ns/1ns
module fan_bank_model (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] fan_drive_three_i,      // Duty to fan three
	input  wire logic       sense_two_on_three_i,   // Tach two grouped
	input  wire logic       sense_three_on_three_i, // Tach three grouped
	input  wire logic       sense_four_on_three_i,  // Tach four grouped
	output logic      [1:0] fans_on_three_o,        // Fans measured
	output logic      [7:0] speed_three_o           // Fan three speed
);
	// ---------------------------------------------------------------
	// Fan response
	// ---------------------------------------------------------------
	// Speed lags duty by a cycle; a real fan lags far more, but the
	// bench only needs to see that the drive reaches the fan
	always_ff @(posedge core_clk_i) begin
		speed_three_o <= fan_drive_three_i;
		// Fans sharing drive three are counted per grouped tach
		fans_on_three_o <= 2'(sense_two_on_three_i) +
			2'(sense_three_on_three_i) + 2'(sense_four_on_three_i);
	end
endmodule : fan_bank_model

// [testbench/tb_top.sv]
// Self-checking bench of the acoustic smoothing block
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int unsigned FAST = 10; // Short slots keep the run brief
	localparam int unsigned SLOW = 14;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic  [7:0] addr = 8'h00;
	logic  [7:0] wdata = 8'h00;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic  [7:0] rdata;
	logic  [7:0] target = 8'h00;
	logic  [7:0] bypass = 8'h00;
	logic  [2:0] ctl = 3'h0;
	logic  [2:0] auto = 3'h0;
	logic  [2:0] below = 3'h0;
	logic  [7:0] mins [3] = '{8'h00, 8'h00, 8'h00};
	logic  [7:0] drv [3];
	logic  [2:0] algn;
	logic  [1:0] fans3;
	logic  [7:0] spd3;
	int          num_errors = 0;
	int          n_checks = 0;
	logic [31:0] seed = 32'h000176B7; // Fixed start of the sequence
	int          incs [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

	// Clock of 4 ns
	always #2 clk = ~clk;

	fan_drive_acoustic_smoothing #(
		.SLOT_FAST_CYCLES(FAST),
		.SLOT_SLOW_CYCLES(SLOW)
	) fan_drive_acoustic_smoothing_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(rdata), .remote_one_target_i(target),
		.bypass_duty_i(bypass), .remote_one_controls_i(ctl),
		.auto_mode_i(auto), .below_floor_i(below),
		.min_duty_one_i(mins[0]), .min_duty_two_i(mins[1]),
		.min_duty_three_i(mins[2]), .fan_drive_one_o(drv[0]),
		.fan_drive_two_o(drv[1]), .fan_drive_three_o(drv[2]),
		.speed_sense_two_aligned_o(algn[0]),
		.speed_sense_three_aligned_o(algn[1]),
		.speed_sense_four_aligned_o(algn[2]));

	fan_bank_model fan_bank_model_inst (
		.core_clk_i(clk), .fan_drive_three_i(drv[2]),
		.sense_two_on_three_i(algn[0]), .sense_three_on_three_i(algn[1]),
		.sense_four_on_three_i(algn[2]), .fans_on_three_o(fans3),
		.speed_three_o(spd3));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// Expected duty of output n with smoothing off
	function automatic logic [7:0] exp_drive(int n, logic [7:0] ctrl);
		if (auto[n] && below[n])
			return ctrl[5 + n] ? mins[n] : 8'h00;
		return ctl[n] ? target : bypass;
	endfunction : exp_drive

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// Ramp from 0 to 100 and check each step, and the spacing of every step after the first
	task automatic ramp(input logic [2:0] code, input logic [7:0] cfg);
		int per;
		int gap;
		int prev;
		int want;
		logic [7:0] rb;
		per = int'(cfg[1] ? SLOW : FAST) * (cfg[2] ? 4 : 1);
		wr(8'h70, cfg);
		wr(8'h62, {5'h01, code});
		target <= 8'd100;
		prev = 0;
		gap = -1;
		for (int c = 0; c < 20000 && prev != 100; c++) begin
			@(posedge clk);
			#1 gap++;
			if (drv[0] !== 8'(prev)) begin
				want = (prev + incs[code] > 100) ? 100 : prev + incs[code];
				`CHK(drv[0], 8'(want))
				if (prev != 0)
					`CHK(gap, per)
				gap = 0;
				prev = int'(drv[0]);
			end
		end
		`CHK(prev, 100)
		rd(8'h71, rb);
		`CHK(rb, 8'h64)
		wr(8'h62, 8'h00);
		target <= 8'h00;
		repeat (3) @(posedge clk);
	endtask : ramp

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] v;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h62, d);
		`CHK(d, 8'h00)
		@(posedge clk) #1 `CHK(rdata, 8'h00)
		rd(8'h5A, d);
		`CHK(d, 8'h00)
		// Random floors, groupings and sources with smoothing off
		for (int i = 0; i < 24; i++) begin
			v = rnd() & 8'hF7;
			wr(8'h62, v);
			target <= rnd();
			bypass <= rnd();
			ctl <= 3'(rnd());
			auto <= 3'(rnd());
			below <= 3'(rnd());
			for (int n = 0; n < 3; n++)
				mins[n] <= rnd();
			repeat (3) @(posedge clk);
			#1 `CHK(algn, {2'h3, v[4]})
			`CHK(fans3, (v[4] ? 2'h3 : 2'h2))
			`CHK(spd3, exp_drive(2, v))
			for (int n = 0; n < 3; n++)
				`CHK(drv[n], exp_drive(n, v))
			rd(8'h62, d);
			`CHK(d, v)
		end
		// Every rate code fast, then slow and quartered extremes
		ctl <= 3'h7;
		auto <= 3'h0;
		wr(8'h62, 8'h00);
		target <= 8'h00;
		for (int c = 0; c < 8; c++)
			ramp(3'(c), 8'h00);
		for (int c = 0; c < 8; c += 7) begin
			ramp(3'(c), 8'h02);
			ramp(3'(c), 8'h06);
		end
		// Lock freezes both registers until reset
		wr(8'h70, 8'h01);
		wr(8'h62, 8'h5A);
		wr(8'h70, 8'h06);
		rd(8'h62, d);
		`CHK(d, 8'h00)
		rd(8'h70, d);
		`CHK(d, 8'h01)
		summarize();
	end

	// Hang guard well beyond the expected ramp time
	initial begin
		#(30000 * 4);
		num_errors++;
		summarize();
	end
endmodule : tb_top
